/* File: hw/irm_pkg.sv */
// Package of offsets, field layouts and reset values for the receive mask and seed registers
package irm_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CHAN_N = 4;
  localparam int BW_W = 13;

  // Register byte offsets
  localparam logic [7:0] OFS_RX_EVENT_SET = 8'hA0;
  localparam logic [7:0] OFS_RX_EVENT_CLEAR = 8'hA4;
  localparam logic [7:0] OFS_RX_MASK_SET = 8'hA8;
  localparam logic [7:0] OFS_RX_MASK_CLEAR = 8'hAC;
  localparam logic [7:0] OFS_BW_SEED = 8'hB0;
  localparam logic [7:0] OFS_CHAN_SEED_UPPER = 8'hB4;
  localparam logic [7:0] OFS_CHAN_SEED_LOWER = 8'hB8;
  localparam logic [7:0] OFS_SOFT_RESET = 8'hBC;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'hC0;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'hC4;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'hC8;

  // Reset values
  localparam logic [CHAN_N-1:0] RST_RX_MASK = 4'h0;
  localparam logic [CHAN_N-1:0] RST_RX_EVENT = 4'h0;
  localparam logic [BW_W-1:0] RST_BW_SEED = 13'h1333;
  localparam logic [31:0] RST_CHAN_SEED = 32'hFFFFFFFF;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h00000000;

  // Soft reset control bit
  localparam int SOFT_RESET_BIT = 0;

  // Interrupt status layout: one sticky bit per event kind
  localparam int IRQ_N = 3;
  localparam int IRQ_RX_SUMMARY = 0;
  localparam int IRQ_CSR_LOAD = 1;
  localparam int IRQ_SOFT_RESET = 2;
  localparam logic [IRQ_N-1:0] RST_IRQ = 3'h0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } irm_bus_req_t;

  typedef struct packed {
    logic load;
    logic [BW_W-1:0] bandwidth;
    logic [31:0] channels_upper;
    logic [31:0] channels_lower;
  } irm_csr_load_t;

endpackage

/* File: hw/irm_rx_event.sv */
// Receive event bits: set on a rising channel edge or by software, cleared by software
module irm_rx_event
  import irm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [CHAN_N-1:0] chan_irq,
  input wire logic [CHAN_N-1:0] sw_set,
  input wire logic [CHAN_N-1:0] sw_clear,
  output logic [CHAN_N-1:0] event_bits
);

  logic [CHAN_N-1:0] chan_irq_prev;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chan_irq_prev <= RST_RX_EVENT;
    end else begin
      chan_irq_prev <= chan_irq;
    end
  end

  // Set wins over a clear in the same cycle, so no edge is lost
  genvar g;
  generate
    for (g = 0; g < CHAN_N; g++) begin : g_bit
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          event_bits[g] <= 1'b0;
        end else if ((chan_irq[g] && !chan_irq_prev[g]) || sw_set[g]) begin
          event_bits[g] <= 1'b1;
        end else if (sw_clear[g]) begin
          event_bits[g] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

/* File: hw/irm_regs.sv */
// Receive interrupt mask, bus-management seed registers and their CSR load path
//
// Overview of operation
// - Per-channel mask gates receive events into summary IRQ; set at A8h, clear at ACh.
// - Reading the set or clear mask address returns the mask unchanged.
// - Mask bits align with event bits; only bits 3..0 exist, rest read zero.
// - 13-bit bandwidth seed is writable, resets to 1333h, keeps value on bus reset.
// - Bandwidth seed bits 31..13 always read zero.
// - Global, host bus or 1394 bus reset copies bandwidth seed into its CSR.
// - Upper channel seed resets to all ones, copied into upper channels CSR on resets.
// - Lower channel seed resets to all ones, copied into lower channels CSR on resets.
// - Writing one at set address sets a bit, at clear address clears; zero ignored.
// - Reading the event clear address returns events ANDed with the mask.
module irm_regs
  import irm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [CHAN_N-1:0] rx_chan_irq,
  input wire logic global_reset_pin,
  input wire logic host_bus_reset_pin,
  input wire logic link_bus_reset,
  output logic iso_receive_summary_irq,
  output irm_csr_load_t csr_load,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  irm_bus_req_t req;
  assign req.addr = reg_addr;
  assign req.wdata = reg_wdata;
  assign req.wr = reg_wr;
  assign req.rd = reg_rd;

  function automatic logic hit_wr(input irm_bus_req_t r, input logic [7:0] ofs);
    hit_wr = r.wr && (r.addr == ofs);
  endfunction

  logic [CHAN_N-1:0] rx_mask;
  logic [CHAN_N-1:0] rx_events;
  logic [BW_W-1:0] bandwidth_seed_field;
  logic [31:0] channel_seed_upper_field;
  logic [31:0] channel_seed_lower_field;
  logic [IRQ_N-1:0] irq_status;
  logic [IRQ_N-1:0] irq_enable;
  logic soft_reset;
  logic [CHAN_N-1:0] ev_set;
  logic [CHAN_N-1:0] ev_clear;
  logic any_reset_load;
  logic reset_load_prev;
  logic summary_prev;

  // Software reset pulse restores seeds and mask like a hardware reset
  assign soft_reset = hit_wr(req, OFS_SOFT_RESET) && reg_wdata[SOFT_RESET_BIT];

  assign ev_set = hit_wr(req, OFS_RX_EVENT_SET) ? reg_wdata[CHAN_N-1:0] : RST_RX_EVENT;
  assign ev_clear = hit_wr(req, OFS_RX_EVENT_CLEAR) ? reg_wdata[CHAN_N-1:0] : RST_RX_EVENT;

  ////////////////////////////////////////////////////////////////////////////
  // Receive event bits

  irm_rx_event i_irm_rx_event (
    .sys_clk(sys_clk),
    .rst(rst),
    .chan_irq(rx_chan_irq),
    .sw_set(ev_set),
    .sw_clear(ev_clear),
    .event_bits(rx_events)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Receive mask

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_mask <= RST_RX_MASK;
    end else if (soft_reset) begin
      rx_mask <= RST_RX_MASK;
    end else if (hit_wr(req, OFS_RX_MASK_SET)) begin
      rx_mask <= rx_mask | reg_wdata[CHAN_N-1:0];
    end else if (hit_wr(req, OFS_RX_MASK_CLEAR)) begin
      rx_mask <= rx_mask & ~reg_wdata[CHAN_N-1:0];
    end
  end

  // Combinational so the summary follows events and mask in the same cycle
  assign iso_receive_summary_irq = |(rx_events & rx_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Seed registers; a 1394 bus reset does not touch them

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bandwidth_seed_field <= RST_BW_SEED;
    end else if (soft_reset) begin
      bandwidth_seed_field <= RST_BW_SEED;
    end else if (hit_wr(req, OFS_BW_SEED)) begin
      bandwidth_seed_field <= reg_wdata[BW_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      channel_seed_upper_field <= RST_CHAN_SEED;
    end else if (soft_reset) begin
      channel_seed_upper_field <= RST_CHAN_SEED;
    end else if (hit_wr(req, OFS_CHAN_SEED_UPPER)) begin
      channel_seed_upper_field <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      channel_seed_lower_field <= RST_CHAN_SEED;
    end else if (soft_reset) begin
      channel_seed_lower_field <= RST_CHAN_SEED;
    end else if (hit_wr(req, OFS_CHAN_SEED_LOWER)) begin
      channel_seed_lower_field <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CSR load strobe
  // The load fires once, the cycle after the OR of all reset sources falls, so the CSRs
  // see the seed as it stands when the reset ends, not a stale earlier copy.

  assign any_reset_load = global_reset_pin || host_bus_reset_pin || link_bus_reset;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reset_load_prev <= 1'b0;
    end else begin
      reset_load_prev <= any_reset_load;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      csr_load.load <= 1'b0;
      csr_load.bandwidth <= RST_BW_SEED;
      csr_load.channels_upper <= RST_CHAN_SEED;
      csr_load.channels_lower <= RST_CHAN_SEED;
    end else begin
      csr_load.load <= reset_load_prev && !any_reset_load;
      if (reset_load_prev && !any_reset_load) begin
        csr_load.bandwidth <= bandwidth_seed_field;
        csr_load.channels_upper <= channel_seed_upper_field;
        csr_load.channels_lower <= channel_seed_lower_field;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, enable and clear

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      summary_prev <= 1'b0;
    end else begin
      summary_prev <= iso_receive_summary_irq;
    end
  end

  logic [IRQ_N-1:0] irq_events;
  assign irq_events[IRQ_RX_SUMMARY] = iso_receive_summary_irq && !summary_prev;
  assign irq_events[IRQ_CSR_LOAD] = reset_load_prev && !any_reset_load;
  assign irq_events[IRQ_SOFT_RESET] = soft_reset;

  // A new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_status <= RST_IRQ;
    end else if (hit_wr(req, OFS_IRQ_CLEAR)) begin
      irq_status <= (irq_status & ~reg_wdata[IRQ_N-1:0]) | irq_events;
    end else begin
      irq_status <= irq_status | irq_events;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_enable <= RST_IRQ;
    end else if (hit_wr(req, OFS_IRQ_ENABLE)) begin
      irq_enable <= reg_wdata[IRQ_N-1:0];
    end
  end

  assign irq = |(irq_status & irq_enable);

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe; unmapped offsets read zero

  logic [DATA_W-1:0] next_rdata;

  always_comb begin
    next_rdata = READ_ZERO;
    case (reg_addr)
      OFS_RX_EVENT_SET: next_rdata[CHAN_N-1:0] = rx_events;
      OFS_RX_EVENT_CLEAR: next_rdata[CHAN_N-1:0] = rx_events & rx_mask;
      OFS_RX_MASK_SET: next_rdata[CHAN_N-1:0] = rx_mask;
      OFS_RX_MASK_CLEAR: next_rdata[CHAN_N-1:0] = rx_mask;
      OFS_BW_SEED: next_rdata[BW_W-1:0] = bandwidth_seed_field;
      OFS_CHAN_SEED_UPPER: next_rdata = channel_seed_upper_field;
      OFS_CHAN_SEED_LOWER: next_rdata = channel_seed_lower_field;
      OFS_IRQ_STATUS: next_rdata[IRQ_N-1:0] = irq_status;
      OFS_IRQ_ENABLE: next_rdata[IRQ_N-1:0] = irq_enable;
      default: next_rdata = READ_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= READ_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= READ_ZERO;
    end
  end

endmodule

/* File: tb/irm_regs_properties.sv */
// Port-level checks for the receive mask and seed register block
module irm_regs_properties
  import irm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic [CHAN_N-1:0] rx_chan_irq,
  input wire logic global_reset_pin,
  input wire logic host_bus_reset_pin,
  input wire logic link_bus_reset,
  input wire logic iso_receive_summary_irq,
  input wire irm_csr_load_t csr_load,
  input wire logic irq
);
  logic any_rst;
  assign any_rst = global_reset_pin | host_bus_reset_pin | link_bus_reset;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  mask_hi_zero_a: assert property (reg_rd && reg_addr == OFS_RX_MASK_CLEAR
    |=> reg_rdata[31:4] == 28'h0) else $error("mask upper bits set");
  bw_hi_zero_a: assert property (reg_rd && reg_addr == OFS_BW_SEED
    |=> reg_rdata[31:13] == 19'h0) else $error("bandwidth upper bits set");
  mask_set_a: assert property (reg_wr && reg_addr == OFS_RX_MASK_SET ##1
    reg_rd && reg_addr == OFS_RX_MASK_SET |=> (reg_rdata[3:0] & $past(reg_wdata[3:0], 2))
    == $past(reg_wdata[3:0], 2)) else $error("mask bit not set");
  mask_clear_a: assert property (reg_wr && reg_addr == OFS_RX_MASK_CLEAR ##1
    reg_rd && reg_addr == OFS_RX_MASK_CLEAR |=> (reg_rdata[3:0] & $past(reg_wdata[3:0], 2))
    == 4'h0) else $error("mask bit not cleared");
  bw_write_a: assert property (reg_wr && reg_addr == OFS_BW_SEED ##1
    reg_rd && reg_addr == OFS_BW_SEED |=> reg_rdata[12:0] == $past(reg_wdata[12:0], 2))
    else $error("bandwidth seed lost write");
  upper_write_a: assert property (reg_wr && reg_addr == OFS_CHAN_SEED_UPPER ##1
    reg_rd && reg_addr == OFS_CHAN_SEED_UPPER |=> reg_rdata == $past(reg_wdata, 2))
    else $error("upper seed lost write");
  load_after_a: assert property (!any_rst && $past(any_rst)
    |-> ##[0:1] csr_load.load) else $error("no load after reset source");
  load_cause_a: assert property (csr_load.load |-> $past(any_rst) || $past(any_rst, 2))
    else $error("load without reset source");
  load_one_a: assert property (csr_load.load |=> !csr_load.load)
    else $error("load longer than one cycle");
  load_hold_a: assert property (!csr_load.load |-> $stable({csr_load.bandwidth,
    csr_load.channels_upper, csr_load.channels_lower}))
    else $error("load data moved without load");
  summary_a: assert property (reg_rd && reg_addr == OFS_RX_EVENT_CLEAR ##1
    reg_rdata[3:0] != 4'h0 |-> iso_receive_summary_irq) else $error("summary low");
endmodule

/* File: tb/irm_regs_tb.sv */
// Self-checking bench for the receive mask and seed register block
module irm_regs_tb
  import irm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 32'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [CHAN_N-1:0] rx_chan_irq = 4'h0;
  logic global_reset_pin = 1'h0;
  logic host_bus_reset_pin = 1'h0;
  logic link_bus_reset = 1'h0;
  logic [DATA_W-1:0] reg_rdata;
  logic iso_receive_summary_irq;
  logic irq;
  irm_csr_load_t csr_load;
  logic rd_d = 1'h0;
  logic [31:0] q[$];
  int fail_count = 0;
  int comparisons = 0;
  int seed = 71;
  logic [31:0] m, ev, b, u, l;
  irm_regs i_irm_regs (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_chan_irq(rx_chan_irq), .global_reset_pin(global_reset_pin),
    .host_bus_reset_pin(host_bus_reset_pin), .link_bus_reset(link_bus_reset),
    .iso_receive_summary_irq(iso_receive_summary_irq), .csr_load(csr_load), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Every call assigns each strobe once, so back-to-back cycles never double-drive
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    op(1'h1, 1'h0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    op(1'h0, 1'h1, a, 32'h0);
  endtask
  task automatic idle();
    op(1'h0, 1'h0, 8'h00, 32'h0);
  endtask
  task automatic chk_irq(input logic s, input logic i);
    idle();
    @(negedge sys_clk);
    cmp({30'h0, iso_receive_summary_irq, irq}, {30'h0, s, i});
    @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) rd_d <= reg_rd;
  always @(negedge sys_clk) begin
    if (rd_d === 1'h1) begin
      cmp(reg_rdata, q.pop_front());
    end
    if (csr_load.load === 1'h1) begin
      cmp({19'h0, csr_load.bandwidth}, q.pop_front());
      cmp(csr_load.channels_upper, q.pop_front());
      cmp(csr_load.channels_lower, q.pop_front());
    end
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    rd(OFS_BW_SEED, 32'h00001333);
    rd(OFS_CHAN_SEED_UPPER, 32'hFFFFFFFF);
    rd(OFS_CHAN_SEED_LOWER, 32'hFFFFFFFF);
    rd(OFS_RX_MASK_SET, 32'h0);
    rd(8'hF0, 32'h0);
    idle();
    $display("test reset values done");
    m = $random(seed);
    wr(OFS_RX_MASK_SET, m);
    m = m & 32'hF;
    rd(OFS_RX_MASK_SET, m);
    rd(OFS_RX_MASK_CLEAR, m);
    b = $random(seed);
    wr(OFS_RX_MASK_CLEAR, b);
    m = m & ~b & 32'hF;
    rd(OFS_RX_MASK_SET, m);
    wr(OFS_RX_MASK_CLEAR, 32'hF);
    wr(OFS_RX_MASK_SET, 32'h5);
    m = 32'h5;
    idle();
    $display("test mask done");
    ev = 32'h0;
    for (int i = 0; i < CHAN_N; i++) begin
      rx_chan_irq[i] <= 1'h1;
      ev[i] = 1'h1;
      repeat (2) idle();
      rd(OFS_RX_EVENT_CLEAR, ev & m);
      rd(OFS_RX_EVENT_SET, ev);
      chk_irq(1'h1, 1'h0);
    end
    wr(OFS_IRQ_ENABLE, 32'h1);
    chk_irq(1'h1, 1'h1);
    rd(OFS_IRQ_STATUS, 32'h1);
    wr(OFS_IRQ_CLEAR, 32'h7);
    rd(OFS_IRQ_STATUS, 32'h0);
    chk_irq(1'h1, 1'h0);
    wr(OFS_RX_MASK_CLEAR, 32'h5);
    chk_irq(1'h0, 1'h0);
    rd(OFS_RX_EVENT_CLEAR, 32'h0);
    wr(OFS_RX_EVENT_CLEAR, 32'hF);
    rx_chan_irq <= 4'h0;
    rd(OFS_RX_EVENT_SET, 32'h0);
    idle();
    $display("test events and interrupt done");
    b = $random(seed);
    u = $random(seed);
    l = $random(seed);
    wr(OFS_BW_SEED, b);
    wr(OFS_CHAN_SEED_UPPER, u);
    wr(OFS_CHAN_SEED_LOWER, l);
    b = b & 32'h1FFF;
    rd(OFS_BW_SEED, b);
    idle();
    for (int k = 0; k < 3; k++) begin
      {global_reset_pin, host_bus_reset_pin, link_bus_reset} <= 3'h1 << k;
      q.push_back(b);
      q.push_back(u);
      q.push_back(l);
      repeat (2) @(posedge sys_clk);
      {global_reset_pin, host_bus_reset_pin, link_bus_reset} <= 3'h0;
      repeat (4) @(posedge sys_clk);
      cmp(32'(q.size()), 32'h0);
    end
    rd(OFS_BW_SEED, b);
    rd(OFS_CHAN_SEED_LOWER, l);
    rd(OFS_IRQ_STATUS, 32'h2);
    idle();
    $display("test seed loads done");
    wr(OFS_SOFT_RESET, 32'h1);
    idle();
    rd(OFS_BW_SEED, 32'h00001333);
    rd(OFS_CHAN_SEED_UPPER, 32'hFFFFFFFF);
    rd(OFS_CHAN_SEED_LOWER, 32'hFFFFFFFF);
    rd(OFS_IRQ_STATUS, 32'h6);
    repeat (2) idle();
    $display("test soft reset done");
    end_sim();
  end
endmodule
bind irm_regs irm_regs_properties i_irm_regs_properties (.sys_clk(sys_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rx_chan_irq(rx_chan_irq), .global_reset_pin(global_reset_pin),
  .host_bus_reset_pin(host_bus_reset_pin), .link_bus_reset(link_bus_reset),
  .iso_receive_summary_irq(iso_receive_summary_irq), .csr_load(csr_load), .irq(irq));
